// ==== rbbi_pkg.sv ====
package rbbi_pkg;
   // Rod and gang geometry
   localparam int NROD = 32;
   localparam int ROD_IW = 5;
   localparam int GANG_SIZE = 4;
   localparam int NGANG = NROD / GANG_SIZE;
   localparam int POS_W = 16;
   // Position lsb is 0.1 mm, so 38.1 mm is 381 counts
   localparam real MISALIGN_MM = 38.1;
   localparam logic [POS_W-1:0] MISALIGN_LIM = POS_W'(int'(MISALIGN_MM * 10.0));
   localparam logic [5:0] INOP_MAX = 6'h08;
   localparam logic [5:0] INOP_MAX_REFUEL = 6'h15;
   localparam logic [NROD-1:0] HCU_PAIR = 32'h00000003;
   localparam int HCU_SHIFT = 2;
   // Reactor mode pin encoding
   localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
   localparam logic [1:0] MODE_REFUEL = 2'h1;
   localparam logic [1:0] MODE_STARTUP = 2'h2;
   localparam logic [1:0] MODE_RUN = 2'h3;
   // Per-channel block condition bit positions
   localparam int NCOND = 22;
   localparam int C_CHG_PRESS = 0;
   localparam int C_CHG_BYP = 1;
   localparam int C_SCRAM = 2;
   localparam int C_ALT_INS = 3;
   localparam int C_SEL_RUNIN = 4;
   localparam int C_POS_TRBL = 5;
   localparam int C_SRM_PERIOD = 6;
   localparam int C_SRM_DOWN = 7;
   localparam int C_SRM_UP = 8;
   localparam int C_SRM_INOP = 9;
   localparam int C_APM_SETDN_UP = 10;
   localparam int C_APM_DOWN = 11;
   localparam int C_FLOW_BIAS = 12;
   localparam int C_APM_INOP = 13;
   localparam int C_SEQ_VIOL = 14;
   localparam int C_SEQ_TRBL = 15;
   localparam int C_TLM_BLK = 16;
   localparam int C_TLM_TRBL = 17;
   localparam int C_MCB_BLK = 18;
   localparam int C_MCB_INOP = 19;
   localparam int C_PUMP_TRIP = 20;
   localparam int C_REFUEL_IL = 21;
   // Channel bypass field: bit 0 thermal limit, 1 sequence, 2 position; B channel is +3
   localparam int NBYP = 3;
   localparam int BYP_B_POS = 3;
   // Register byte offsets
   localparam logic [7:0] REG_BYPASS = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_INOP_STAGE = 8'h08;
   localparam logic [7:0] REG_CMD = 8'h0C;
   localparam logic [7:0] REG_INOP = 8'h10;
   localparam logic [7:0] REG_OVR = 8'h14;
   localparam logic [7:0] REG_SYN_BYP = 8'h18;
   localparam logic [7:0] REG_SUBST_EN = 8'h1C;
   localparam logic [7:0] REG_SUBST = 8'h20;
   localparam logic [7:0] REG_ROD_BLOCK = 8'h24;
   // Status bit positions
   localparam int ST_AUTO = 0;
   localparam int ST_ANY_BLOCK = 1;
   localparam int ST_MISALIGN = 2;
   localparam int ST_LOAD_DONE = 3;
   localparam int ST_LOAD_REJ = 4;
   localparam int ST_BYP_REF = 5;
   localparam int ST_OVR_REF = 6;
   localparam int CMD_LOAD = 0;
   localparam int SUBST_ROD_POS = 16;
   // Reset values
   localparam logic [NROD-1:0] ROD_RST = 32'h00000000;
   localparam logic [POS_W-1:0] POS_RST = 16'h0000;
   typedef enum logic {RBBI_MANUAL, RBBI_AUTO} rbbi_auto_type;
endpackage : rbbi_pkg

// ==== rbbi_pos_unit.sv ====
`timescale 1ns/1ps
module rbbi_pos_unit import rbbi_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic in_valid,
   input wire logic [ROD_IW-1:0] in_rod,
   input wire logic [POS_W-1:0] pri_pos,
   input wire logic [POS_W-1:0] sec_pos,
   input wire logic [NROD-1:0] syn_byp,
   input wire logic [NROD-1:0] subst_en,
   input wire logic [NROD-1:0] inop,
   input wire logic [ROD_IW-1:0] subst_rod,
   input wire logic [POS_W-1:0] subst_pos,
   output logic out_valid,
   output logic [ROD_IW-1:0] out_rod,
   output logic [POS_W-1:0] out_pos,
   output logic misalign
);
   typedef struct packed {
      logic [NROD-1:0][POS_W-1:0] pos;
      logic valid;
      logic [ROD_IW-1:0] rod;
      logic [POS_W-1:0] eff;
      logic misalign;
   } rbbi_pos_state_type;

   rbbi_pos_state_type st_r;
   rbbi_pos_state_type st_nxt;
   logic [NGANG-1:0] gang_bad;

   function automatic logic [POS_W-1:0] rbbi_absdiff(input logic [POS_W-1:0] a, input logic [POS_W-1:0] b);
      return (a > b) ? a - b : b - a;
   endfunction : rbbi_absdiff

   // Pairwise spread check inside each gang
   generate
      for (genvar g = 0; g < NGANG; g++) begin : g_gang
         logic [GANG_SIZE*GANG_SIZE-1:0] pair_bad;
         for (genvar i = 0; i < GANG_SIZE; i++) begin : g_i
            for (genvar j = 0; j < GANG_SIZE; j++) begin : g_j
               assign pair_bad[i*GANG_SIZE+j] = (i < j) &&
                  (rbbi_absdiff(st_r.pos[g*GANG_SIZE+i], st_r.pos[g*GANG_SIZE+j]) > MISALIGN_LIM);
            end
         end
         assign gang_bad[g] = |pair_bad;
      end
   endgenerate

   always_comb begin
      logic [POS_W-1:0] p;
      p = POS_RST;
      st_nxt = st_r;
      st_nxt.valid = 1'b0;
      st_nxt.misalign = |gang_bad;
      if (in_valid) begin
         p = syn_byp[in_rod] ? sec_pos : pri_pos;
         if (inop[in_rod] && subst_en[in_rod] && (subst_rod == in_rod)) begin
            p = subst_pos;
         end
         st_nxt.pos[in_rod] = p;
         st_nxt.valid = 1'b1;
         st_nxt.rod = in_rod;
         st_nxt.eff = p;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign out_valid = st_r.valid;
   assign out_rod = st_r.rod;
   assign out_pos = st_r.eff;
   assign misalign = st_r.misalign;
endmodule : rbbi_pos_unit

// ==== rbbi_interlock.sv ====
// Functional notes
// - Any block except an inoperable rod drops rod control to manual
// - Auto again only after clear and selector
// - Block conditions are OR of both channels
// - Separation blocks only the separated rods
// - Always-applicable conditions block all rods
// - Source range and setdown alarms outside run
// - Power monitor blocks only in run mode
// - Sequence violation blocks selection below setpoint
// - Thermal and multichannel blocks above setpoint
// - Platform interlock blocks only in refuel
// - Gang spread over 38.1 mm blocks all
// - Blocks follow their conditions, no latch; one channel bypass clears
// - Synchro bypass routes secondary position
// - Inoperable bypass limit eight, 21 refuel
// - Inoperable load needs manual, both keys
// - Substituted position replaces measured position
// - Inoperable rods never get movement pulses
// - Override rods unchecked, manual movement only
// - Override at most two, same hydraulic unit
// - Override leaves insertion and monitors alone
// - Refuse dual bypass; only inoperable rods lose insertion
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module rbbi_interlock import rbbi_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [NCOND-1:0] cond_a,
   input wire logic [NCOND-1:0] cond_b,
   input wire logic [NROD-1:0] sep_a,
   input wire logic [NROD-1:0] sep_b,
   input wire logic [1:0] reactor_mode,
   input wire logic above_lpsp,
   input wire logic auto_select,
   input wire logic key_a,
   input wire logic key_b,
   input wire logic [NROD-1:0] sel_rods,
   input wire logic [NROD-1:0] withdraw_req,
   input wire logic [NROD-1:0] insert_req,
   input wire logic pos_valid,
   input wire logic [ROD_IW-1:0] pos_rod,
   input wire logic [POS_W-1:0] pos_pri,
   input wire logic [POS_W-1:0] pos_sec,
   output logic [NROD-1:0] rod_block,
   output logic [NROD-1:0] withdraw_en,
   output logic [NROD-1:0] insert_en,
   output logic auto_mode,
   output logic inop_load_ok,
   output logic eff_valid,
   output logic [ROD_IW-1:0] eff_rod,
   output logic [POS_W-1:0] eff_pos
);
   localparam int SYNC_W = 2*NCOND + 2*NROD + 6;

   typedef struct packed {
      logic [SYNC_W-1:0] s1;
      logic [SYNC_W-1:0] s2;
      logic [SYNC_W-1:0] s3;
      logic [SYNC_W-1:0] filt;
      logic sel_prev;
      rbbi_auto_type mode_st;
      logic [2*NBYP-1:0] bypass;
      logic [NROD-1:0] inop_stage;
      logic [NROD-1:0] inop;
      logic [NROD-1:0] ovr;
      logic [NROD-1:0] syn_byp;
      logic [NROD-1:0] subst_en;
      logic [ROD_IW-1:0] subst_rod;
      logic [POS_W-1:0] subst_pos;
      logic [NROD-1:0] rod_block;
      logic [NROD-1:0] withdraw_en;
      logic [NROD-1:0] insert_en;
      logic load_done;
      logic load_rej;
      logic byp_ref;
      logic ovr_ref;
      logic load_ok;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } rbbi_state_type;

   rbbi_state_type st_r;
   rbbi_state_type st_nxt;

   logic [NCOND-1:0] f_cond_a;
   logic [NCOND-1:0] f_cond_b;
   logic [NROD-1:0] f_sep_a;
   logic [NROD-1:0] f_sep_b;
   logic [1:0] f_mode;
   logic f_above;
   logic f_auto_sel;
   logic f_key_a;
   logic f_key_b;
   logic misalign;
   logic pos_out_valid;
   logic [ROD_IW-1:0] pos_out_rod;
   logic [POS_W-1:0] pos_out_pos;

   assign {f_cond_b, f_cond_a, f_sep_b, f_sep_a, f_mode, f_above, f_auto_sel, f_key_a, f_key_b} = st_r.filt;

   // Conditions removed from a channel by that channel's bypass
   function automatic logic [NCOND-1:0] rbbi_byp_mask(input logic [NBYP-1:0] b);
      logic [NCOND-1:0] m;
      m = '0;
      m[C_TLM_BLK] = b[0];
      m[C_TLM_TRBL] = b[0];
      m[C_SEQ_VIOL] = b[1];
      m[C_SEQ_TRBL] = b[1];
      m[C_POS_TRBL] = b[2];
      return m;
   endfunction : rbbi_byp_mask

   function automatic logic [5:0] rbbi_popcount(input logic [NROD-1:0] v);
      logic [5:0] c;
      c = '0;
      for (int i = 0; i < NROD; i++) begin
         c = c + 6'(v[i]);
      end
      return c;
   endfunction : rbbi_popcount

   // Nonzero override set must sit inside one hydraulic unit pair
   function automatic logic rbbi_ovr_ok(input logic [NROD-1:0] v);
      logic ok;
      ok = (v == '0);
      for (int h = 0; h < NROD / HCU_SHIFT; h++) begin
         if ((v & ~(HCU_PAIR << (HCU_SHIFT * h))) == '0) begin
            ok = 1'b1;
         end
      end
      return ok;
   endfunction : rbbi_ovr_ok

   rbbi_pos_unit u_pos (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .in_valid(pos_valid),
      .in_rod(pos_rod),
      .pri_pos(pos_pri),
      .sec_pos(pos_sec),
      .syn_byp(st_r.syn_byp),
      .subst_en(st_r.subst_en),
      .inop(st_r.inop),
      .subst_rod(st_r.subst_rod),
      .subst_pos(st_r.subst_pos),
      .out_valid(pos_out_valid),
      .out_rod(pos_out_rod),
      .out_pos(pos_out_pos),
      .misalign(misalign)
   );

   always_comb begin
      logic [NCOND-1:0] cond;
      logic is_run;
      logic is_refuel;
      logic all_blk;
      logic [NROD-1:0] blk;
      logic [NROD-1:0] special;
      logic access;
      logic wr;
      logic addr_ok;
      logic [31:0] rd;
      logic [2*NBYP-1:0] byp_new;
      logic byp_bad;
      logic load_go;
      logic load_pass;
      logic clr_st;
      cond = '0;
      is_run = 1'b0;
      is_refuel = 1'b0;
      all_blk = 1'b0;
      blk = '0;
      special = '0;
      rd = '0;
      addr_ok = 1'b1;
      byp_new = st_r.bypass;
      byp_bad = 1'b0;
      st_nxt = st_r;

      // Three-stage pin synchroniser, a change counts when stages two and three agree
      st_nxt.s1 = {cond_b, cond_a, sep_b, sep_a, reactor_mode, above_lpsp, auto_select, key_a, key_b};
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      st_nxt.filt = (~(st_r.s2 ^ st_r.s3) & st_r.s3) | ((st_r.s2 ^ st_r.s3) & st_r.filt);

      // Channel merge after per-channel bypass
      cond = (f_cond_a & ~rbbi_byp_mask(st_r.bypass[NBYP-1:0])) |
             (f_cond_b & ~rbbi_byp_mask(st_r.bypass[2*NBYP-1:BYP_B_POS]));
      is_run = (f_mode == MODE_RUN);
      is_refuel = (f_mode == MODE_REFUEL);

      all_blk = (f_mode == MODE_SHUTDOWN) | cond[C_CHG_PRESS] | cond[C_CHG_BYP] | cond[C_SCRAM] |
                cond[C_ALT_INS] | cond[C_SEL_RUNIN] | cond[C_POS_TRBL];
      all_blk = all_blk | (~is_run & (cond[C_SRM_PERIOD] | cond[C_SRM_DOWN] | cond[C_SRM_UP] |
                cond[C_SRM_INOP] | cond[C_APM_SETDN_UP]));
      all_blk = all_blk | (is_run & (cond[C_APM_DOWN] | cond[C_FLOW_BIAS] | cond[C_APM_INOP]));
      all_blk = all_blk | (~f_above & cond[C_SEQ_TRBL]);
      all_blk = all_blk | (f_above & (cond[C_TLM_BLK] | cond[C_TLM_TRBL] | cond[C_MCB_BLK] |
                cond[C_MCB_INOP]));
      all_blk = all_blk | cond[C_PUMP_TRIP];
      all_blk = all_blk | (is_refuel & cond[C_REFUEL_IL]);
      all_blk = all_blk | misalign;

      blk = f_sep_a | f_sep_b;
      if (~f_above && cond[C_SEQ_VIOL]) begin
         blk = blk | (sel_rods & ~st_r.ovr);
      end
      if (all_blk) begin
         blk = '1;
      end
      st_nxt.rod_block = blk | st_r.inop;

      // Withdrawal gated in the same edge as the block register
      st_nxt.withdraw_en = withdraw_req & ~blk & ~st_r.inop &
                           ~((st_r.mode_st == RBBI_AUTO) ? st_r.ovr : ROD_RST);
      special = (cond[C_SCRAM] | cond[C_ALT_INS]) ? '1 : (cond[C_SEL_RUNIN] ? sel_rods : ROD_RST);
      st_nxt.insert_en = (insert_req | special) & ~st_r.inop;

      // Auto/manual selection
      st_nxt.sel_prev = f_auto_sel;
      case (st_r.mode_st)
         RBBI_AUTO: begin
            if (|blk || !f_auto_sel) begin
               st_nxt.mode_st = RBBI_MANUAL;
            end
         end
         RBBI_MANUAL: begin
            if (!(|blk) && f_auto_sel && !st_r.sel_prev) begin
               st_nxt.mode_st = RBBI_AUTO;
            end
         end
         default: begin
            st_nxt.mode_st = RBBI_MANUAL;
         end
      endcase

      // APB: one wait state, write commits at the edge that sees pready high
      access = psel & penable & ~st_r.pready;
      wr = psel & penable & pwrite & st_r.pready;
      case (paddr)
         REG_BYPASS: rd = 32'(st_r.bypass);
         REG_STATUS: rd = 32'({st_r.ovr_ref, st_r.byp_ref, st_r.load_rej, st_r.load_done, misalign,
                          |st_r.rod_block, st_r.mode_st == RBBI_AUTO});
         REG_INOP_STAGE: rd = st_r.inop_stage;
         REG_CMD: rd = '0;
         REG_INOP: rd = st_r.inop;
         REG_OVR: rd = st_r.ovr;
         REG_SYN_BYP: rd = st_r.syn_byp;
         REG_SUBST_EN: rd = st_r.subst_en;
         REG_SUBST: rd = {11'h000, st_r.subst_rod, st_r.subst_pos};
         REG_ROD_BLOCK: rd = st_r.rod_block;
         default: begin
            rd = '0;
            addr_ok = 1'b0;
         end
      endcase
      st_nxt.pready = access;
      st_nxt.pslverr = access & ~addr_ok;
      if (access && !pwrite) begin
         st_nxt.prdata = rd;
      end

      load_go = wr && (paddr == REG_CMD) && pwdata[CMD_LOAD];
      load_pass = (st_r.mode_st == RBBI_MANUAL) && f_key_a && f_key_b &&
                  (rbbi_popcount(st_r.inop_stage) <= (is_refuel ? INOP_MAX_REFUEL : INOP_MAX));
      st_nxt.load_ok = load_go & load_pass;
      if (load_go && load_pass) begin
         st_nxt.inop = st_r.inop_stage;
      end

      if (wr) begin
         case (paddr)
            REG_BYPASS: begin
               for (int i = 0; i < NBYP; i++) begin
                  if (pwdata[i] && pwdata[i+BYP_B_POS]) begin
                     byp_bad = 1'b1;
                  end else begin
                     byp_new[i] = pwdata[i];
                     byp_new[i+BYP_B_POS] = pwdata[i+BYP_B_POS];
                  end
               end
               st_nxt.bypass = byp_new;
            end
            REG_INOP_STAGE: st_nxt.inop_stage = pwdata;
            REG_OVR: begin
               if (rbbi_ovr_ok(pwdata)) begin
                  st_nxt.ovr = pwdata;
               end
            end
            REG_SYN_BYP: st_nxt.syn_byp = pwdata;
            REG_SUBST_EN: st_nxt.subst_en = pwdata;
            REG_SUBST: begin
               st_nxt.subst_rod = pwdata[SUBST_ROD_POS+ROD_IW-1:SUBST_ROD_POS];
               st_nxt.subst_pos = pwdata[POS_W-1:0];
            end
            default: begin
            end
         endcase
      end

      // Sticky status, a set in the clearing cycle wins
      clr_st = wr && (paddr == REG_STATUS);
      st_nxt.load_done = (load_go & load_pass) | (st_r.load_done & ~(clr_st & pwdata[ST_LOAD_DONE]));
      st_nxt.load_rej = (load_go & ~load_pass) | (st_r.load_rej & ~(clr_st & pwdata[ST_LOAD_REJ]));
      st_nxt.byp_ref = byp_bad | (st_r.byp_ref & ~(clr_st & pwdata[ST_BYP_REF]));
      st_nxt.ovr_ref = (wr && (paddr == REG_OVR) && !rbbi_ovr_ok(pwdata)) |
                       (st_r.ovr_ref & ~(clr_st & pwdata[ST_OVR_REF]));
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign prdata = st_r.prdata;
   assign pready = st_r.pready;
   assign pslverr = st_r.pslverr;
   assign rod_block = st_r.rod_block;
   assign withdraw_en = st_r.withdraw_en;
   assign insert_en = st_r.insert_en;
   assign auto_mode = (st_r.mode_st == RBBI_AUTO);
   assign inop_load_ok = st_r.load_ok;
   assign eff_valid = pos_out_valid;
   assign eff_rod = pos_out_rod;
   assign eff_pos = pos_out_pos;
endmodule : rbbi_interlock

// ==== rbbi_interlock_monitor.sv ====
`timescale 1ns/1ps
module rbbi_interlock_monitor import rbbi_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic auto_select,
   input wire logic key_a,
   input wire logic key_b,
   input wire logic [NROD-1:0] withdraw_req,
   input wire logic [NROD-1:0] insert_req,
   input wire logic pos_valid,
   input wire logic [ROD_IW-1:0] pos_rod,
   input wire logic [NROD-1:0] rod_block,
   input wire logic [NROD-1:0] withdraw_en,
   input wire logic [NROD-1:0] insert_en,
   input wire logic auto_mode,
   input wire logic inop_load_ok,
   input wire logic eff_valid,
   input wire logic [ROD_IW-1:0] eff_rod
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn || !ce);
   property p_wd_blk; |withdraw_en |-> (withdraw_en & rod_block) == '0; endproperty
   property p_wd_req;
      !auto_mode && !$past(auto_mode) |-> withdraw_en == ($past(withdraw_req) & ~rod_block);
   endproperty
   property p_blk_man; $rose(|rod_block) |-> ##[0:1] !auto_mode; endproperty
   property p_auto_in; $rose(auto_mode) |-> rod_block == '0 && auto_select; endproperty
   property p_sel_low; !auto_select [*7] |-> !auto_mode; endproperty
   property p_ins; (($past(insert_req) & ~rod_block) & ~insert_en) == '0; endproperty
   property p_load; inop_load_ok |-> key_a && key_b && !auto_mode ##1 !inop_load_ok; endproperty
   property p_apb; psel && penable && !pready |=> pready ##1 !pready; endproperty
   property p_eff; pos_valid |=> eff_valid && eff_rod == $past(pos_rod); endproperty
   a_wd_blk: assert property (p_wd_blk) else $error("withdraw on blocked rod");
   a_wd_req: assert property (p_wd_req) else $error("withdraw enable wrong");
   a_blk_man: assert property (p_blk_man) else $error("block kept auto");
   a_auto_in: assert property (p_auto_in) else $error("auto entered while blocked");
   a_sel_low: assert property (p_sel_low) else $error("auto without selector");
   a_ins: assert property (p_ins) else $error("insertion suppressed");
   a_load: assert property (p_load) else $error("load accepted wrongly");
   a_apb: assert property (p_apb) else $error("pready timing wrong");
   a_eff: assert property (p_eff) else $error("effective position late");
   c_auto: cover property ($rose(auto_mode));
   c_load: cover property (inop_load_ok);
   c_err: cover property (pslverr);
endmodule : rbbi_interlock_monitor

// ==== rbbi_plant_model.sv ====
`timescale 1ns/1ps
module rbbi_plant_model import rbbi_pkg::*; #(
   parameter int PWR_MIN = 25,
   parameter int FLOW_MAX = 36
) (
   input wire logic pclk,
   input wire logic [NCOND-1:0] want_a,
   input wire logic [NCOND-1:0] want_b,
   input wire logic [1:0] pumps,
   input wire logic [6:0] power_pct,
   input wire logic [6:0] flow_pct,
   output logic [NCOND-1:0] cond_a,
   output logic [NCOND-1:0] cond_b
);
   logic trip;
   logic [NCOND-1:0] tv;
   // Pump count, power and flow decide the pump trip block
   assign trip = pumps >= 2'h2 && power_pct > PWR_MIN && flow_pct < FLOW_MAX;
   assign tv = NCOND'(trip) << C_PUMP_TRIP;
   always_ff @(posedge pclk) begin
      cond_a <= want_a | tv;
      cond_b <= want_b | tv;
   end
endmodule : rbbi_plant_model

// ==== rbbi_interlock_bench.sv ====
`timescale 1ns/1ps
module rbbi_interlock_bench import rbbi_pkg::*;;
   logic pclk = 0, presetn = 1, ce = 1, psel = 0, penable = 0, pwrite = 0, pos_valid = 0;
   logic key_a = 0, key_b = 0, auto_select = 0, above_lpsp = 0, hi;
   logic pready, pslverr, re, auto_mode, inop_load_ok, eff_valid;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rv;
   logic [NCOND-1:0] cond_a, cond_b, want_a = '0, want_b = '0, c;
   logic [NROD-1:0] sep_a = '0, sep_b = '0, sel_rods = '0, withdraw_req = '0, insert_req = '0;
   logic [NROD-1:0] rod_block, withdraw_en, insert_en, eb, ex, sl, wq, iq, sp;
   logic [1:0] reactor_mode = '0, pumps = '0, m;
   logic [6:0] power_pct = '0, flow_pct = '0;
   logic [ROD_IW-1:0] pos_rod = '0, eff_rod;
   logic [POS_W-1:0] pos_pri = '0, pos_sec = '0, eff_pos;
   int n_fail = 0, num_checks = 0;
   int nb[4] = '{8, 9, 21, 22};
   rbbi_interlock i_dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .cond_a, .cond_b, .sep_a, .sep_b, .reactor_mode, .above_lpsp, .auto_select,
      .key_a, .key_b, .sel_rods, .withdraw_req, .insert_req, .pos_valid, .pos_rod, .pos_pri, .pos_sec,
      .rod_block, .withdraw_en, .insert_en, .auto_mode, .inop_load_ok, .eff_valid, .eff_rod, .eff_pos);
   rbbi_plant_model i_plant (.pclk, .want_a, .want_b, .pumps, .power_pct, .flow_pct, .cond_a, .cond_b);
   initial forever #2 pclk = ~pclk;
   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask : wt
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      num_checks++;
      if (s !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rv = prdata;
      re = pslverr;
      psel <= 0;
      penable <= 0;
      // Idle edge so the next call never reassigns psel in this time step
      @(posedge pclk);
   endtask : apb
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
      apb(0, a, '0);
      chk(nm, e, rv);
   endtask : rdc
   task automatic pos(input logic [4:0] r, input logic [15:0] p, input logic [15:0] s);
      pos_valid <= 1;
      pos_rod <= r;
      pos_pri <= p;
      pos_sec <= s;
      wt(1);
      pos_valid <= 0;
      wt(1);
   endtask : pos
   function automatic logic [NROD-1:0] exp_blk(logic [NCOND-1:0] c, logic [1:0] m, logic hi,
         logic [NROD-1:0] sl);
      logic a;
      a = (|c[5:0]) || c[C_PUMP_TRIP] || m == MODE_SHUTDOWN;
      a = a || (m != MODE_RUN && |c[10:6]);
      a = a || (m == MODE_RUN && |c[13:11]);
      a = a || (hi ? |c[19:16] : c[C_SEQ_TRBL]);
      a = a || (m == MODE_REFUEL && c[C_REFUEL_IL]);
      return a ? '1 : (!hi && c[C_SEQ_VIOL]) ? sl : '0;
   endfunction : exp_blk
   function automatic logic [NROD-1:0] exp_ins(logic [NCOND-1:0] c, logic [NROD-1:0] sl, iq);
      return (c[C_SCRAM] || c[C_ALT_INS]) ? '1 : iq | (c[C_SEL_RUNIN] ? sl : '0);
   endfunction : exp_ins
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict
   initial begin
      wt(20000);
      n_fail++;
      print_verdict();
   end
   initial begin
      // Falling edge at time zero so the asynchronous reset really fires
      presetn <= 0;
      void'($urandom(75));
      wt(3);
      chk("reset rod_block", '0, rod_block);
      wt(2);
      presetn <= 1;
      for (int i = 0; i < 60; i++) begin
         c = (i % 4 == 0) ? '0 : NCOND'(1) << ($urandom % NCOND);
         m = 2'($urandom);
         hi = 1'($urandom);
         {sl, wq, iq} = {$urandom, $urandom, $urandom};
         sp = (i % 3 == 1) ? NROD'(1) << ($urandom % NROD) : '0;
         pumps <= c[C_PUMP_TRIP] ? 2'h2 : 2'($urandom % 2);
         {power_pct, flow_pct} <= c[C_PUMP_TRIP] ? {7'h1E, 7'h1E} : {7'h5A, 7'h0A};
         c[C_PUMP_TRIP] = c[C_PUMP_TRIP];
         if (i % 2) {want_a, want_b} <= {c & ~(NCOND'(1) << C_PUMP_TRIP), NCOND'(0)};
         else {want_a, want_b} <= {NCOND'(0), c & ~(NCOND'(1) << C_PUMP_TRIP)};
         {sep_a, sep_b} <= (i % 2) ? {sp, NROD'(0)} : {NROD'(0), sp};
         {reactor_mode, above_lpsp, sel_rods, withdraw_req, insert_req} <= {m, hi, sl, wq, iq};
         wt(8);
         eb = exp_blk(c, m, hi, sl) | sp;
         chk("rod_block", eb, rod_block);
         chk("withdraw_en", wq & ~eb, withdraw_en);
         chk("insert_en", exp_ins(c, sl, iq), insert_en);
      end
      $display("test random done");
      {want_a, want_b, sep_a, sep_b, insert_req, pumps} <= '0;
      {reactor_mode, above_lpsp} <= {MODE_RUN, 1'b1};
      apb(1, REG_BYPASS, 32'h09);
      rdc(REG_BYPASS, '0, "bypass both");
      apb(0, REG_STATUS, '0);
      chk("bypass refused", 1, rv[ST_BYP_REF]);
      apb(1, REG_OVR, 32'h5);
      rdc(REG_OVR, '0, "override split");
      apb(1, REG_OVR, 32'hC);
      rdc(REG_OVR, 32'hC, "override pair");
      apb(0, 8'h28, '0);
      chk("unmapped", 1, re);
      apb(1, REG_BYPASS, 32'h01);
      want_a <= NCOND'(1) << C_TLM_BLK;
      wt(8);
      chk("bypassed channel", '0, rod_block);
      {want_a, want_b} <= {NCOND'(0), NCOND'(1) << C_TLM_BLK};
      wt(8);
      chk("other channel", '1, rod_block);
      {want_b, reactor_mode, above_lpsp, sel_rods} <= {NCOND'(1) << C_SEQ_VIOL, MODE_STARTUP, 1'b0, {NROD{1'b1}}};
      apb(1, REG_BYPASS, '0);
      wt(8);
      chk("override violation", ~32'hC, rod_block);
      {want_b, withdraw_req} <= {NCOND'(0), {NROD{1'b1}}};
      wt(8);
      // Selector raised only after the block has cleared
      auto_select <= 1;
      wt(8);
      chk("auto in", 1, auto_mode);
      chk("auto override", ~32'hC, withdraw_en);
      want_a <= NCOND'(1) << C_SCRAM;
      wt(8);
      chk("auto drop", 0, auto_mode);
      want_a <= '0;
      wt(8);
      chk("auto held", 0, auto_mode);
      auto_select <= 0;
      wt(8);
      chk("manual override", '1, withdraw_en);
      $display("test registers and auto done");
      {key_a, key_b, withdraw_req} <= {2'h3, NROD'(0)};
      ex = '0;
      for (int k = 0; k < 5; k++) begin
         reactor_mode <= k < 2 ? MODE_STARTUP : MODE_REFUEL;
         key_b <= k != 4;
         wt(8);
         apb(1, REG_INOP_STAGE, 32'((64'h1 << nb[k % 4]) - 1));
         apb(1, REG_CMD, 32'h1);
         wt(2);
         if (k < 4 && nb[k] <= (k < 2 ? 8 : 21)) ex = 32'((64'h1 << nb[k]) - 1);
         rdc(REG_INOP, ex, "inop");
      end
      key_b <= 1;
      insert_req <= '1;
      wt(3);
      chk("inop insert", ~ex, insert_en);
      chk("inop block", ex, rod_block);
      want_a <= NCOND'(1) << C_ALT_INS;
      wt(8);
      chk("special insert", ~ex, insert_en);
      want_a <= '0;
      $display("test inoperable done");
      apb(1, REG_SUBST, 32'h0003012C);
      apb(1, REG_SUBST_EN, 32'h8);
      pos(5'h18, 16'h0064, 16'h00C8);
      chk("primary pos", 32'h64, eff_pos);
      pos(5'h3, 16'h0064, 16'h00C8);
      chk("subst pos", 32'h12C, eff_pos);
      apb(1, REG_SYN_BYP, 32'h01000000);
      pos(5'h18, 16'h0064, 16'h017D);
      chk("secondary pos", 32'h17D, eff_pos);
      chk("eff rod", 32'h18, eff_rod);
      wt(4);
      chk("gang at limit", ex, rod_block);
      pos(5'h18, 16'h0064, 16'h017E);
      wt(4);
      chk("gang misaligned", '1, rod_block);
      $display("test position done");
      print_verdict();
   end
endmodule : rbbi_interlock_bench
bind rbbi_interlock rbbi_interlock_monitor i_mon (.pclk, .presetn, .ce, .psel, .penable, .pready,
   .pslverr, .auto_select, .key_a, .key_b, .withdraw_req, .insert_req, .pos_valid, .pos_rod,
   .rod_block, .withdraw_en, .insert_en, .auto_mode, .inop_load_ok, .eff_valid, .eff_rod);
